// ===== sp_serial_port.sv
// Serial port: synchronous shift mode and ten-bit asynchronous mode.
// Assumes a one-cycle timer overflow pulse on the system clock.
//
// Overview of operation
// - One address: writes transmit, reads receive buffer.
// - Sync mode: data on rxd, clock on txd.
// - Sync mode: eight bits, least significant first.
// - Sync rate: twelfth or quarter by bit five.
// - Buffer write starts eight-bit shift out.
// - Fast: data lead one, clock low two.
// - Slow: data lead three, clock low six.
// - Sync transmit flag after last bit.
// - Sync receive needs enable high, flag low.
// - Sync receive flag after last rise; halts.
// - Async frame: start, eight bits, stop.
// - Stop bit goes into ninth-bit field.
// - Async rate from timer overflow pulses.
// - Transmit bits on divide-by-16 rollovers.
// - Transmit flag at tenth rollover.
// - Receiver watches falling edge at 16x.
// - Start edge resets receive divide-by-16 counter.
// - Bit is majority of three samples.
// - Start bit voted high aborts reception.
// - Load buffer only when flag clear, checks pass.
// - After stop middle, hunt next edge.
//
// Added by the designer: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
`default_nettype none

module sp_serial_port (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic timer_ovf,
    input wire logic rxd_in,
    output logic rxd_out,
    output logic rxd_oe,
    output logic txd_out
);

    // ****************************************
    // Types and declarations
    // ****************************************

    typedef enum logic [1:0] {M0_IDLE, M0_TX, M0_RX} sp_m0_state_e;
    typedef enum logic {RX_HUNT, RX_BITS} sp_rx_state_e;

    // Control and auxiliary register fields.
    logic [1:0] mode; // Operating mode.
    logic sm2; // Rate select in sync mode, stop check in async mode.
    logic ren; // Receive enable.
    logic tb8; // Ninth transmit bit, stored only.
    logic received_ninth_bit; // Stop bit of the last accepted frame.
    logic tx_done_flag; // Transmission complete.
    logic rx_done_flag; // Reception complete.
    logic rate_double; // Sixteenth divisor of the overflow.

    logic [7:0] serial_buffer; // Receive buffer register.

    // Sync mode state.
    sp_m0_state_e m0_state;
    sp_m0_state_e next_m0_state;
    logic [7:0] m0_shift; // Shared shift register.
    logic [2:0] m0_count; // Bits done.

    // Async transmit state.
    logic [3:0] tx_div; // Free-running divide-by-16.
    logic tx_busy; // Frame in progress.
    logic [9:0] tx_shift; // Frame bits, start bit first.
    logic [3:0] tx_idx; // Bits driven so far.

    // Async receive state.
    sp_rx_state_e rx_state;
    logic [3:0] rx_div; // Divide-by-16 aligned to the start edge.
    logic [3:0] rx_idx; // Bit time within the frame.
    logic [1:0] rx_votes; // First two samples of the current bit.
    logic [7:0] rx_data; // Bits assembled so far.
    logic rxd_prev; // Line level at the previous tick.

    // Pin synchroniser; the first stage feeds only the second.
    logic rxd_meta;
    logic rxd_s;

    sp_rate_if rif();

    // ****************************************
    // Register decode
    // ****************************************

    wire is_m0 = (mode == sp_pkg::MODE_SYNC);
    wire is_m1 = (mode == sp_pkg::MODE_ASYNC);
    wire sel_ctrl = (reg_addr == sp_pkg::ADDR_CTRL);
    wire sel_buf = (reg_addr == sp_pkg::ADDR_BUF);
    wire sel_aux = (reg_addr == sp_pkg::ADDR_AUX);
    wire wr_ctrl = reg_wr && sel_ctrl;
    wire wr_buf = reg_wr && sel_buf;
    wire wr_aux = reg_wr && sel_aux;
    wire [7:0] ctrl_value = {mode, sm2, ren, tb8, received_ninth_bit, tx_done_flag, rx_done_flag};
    wire [7:0] aux_value = {7'h00, rate_double};
    // Unmapped offsets read as zero.
    wire [7:0] read_mux = sel_ctrl ? ctrl_value :
                          sel_buf ? serial_buffer :
                          sel_aux ? aux_value : 8'h00;

    // ****************************************
    // Rate generator
    // ****************************************

    assign rif.m0_run = (m0_state != M0_IDLE);
    assign rif.m0_fast = sm2;
    assign rif.ovf = timer_ovf;
    assign rif.rate_double = rate_double;

    sp_rate_gen sp_rate_gen_i (
        .clock(clock),
        .rst_n(rst_n),
        .rif(rif)
    );

    // ****************************************
    // Synchroniser
    // ****************************************

    // Two stages before the async receiver looks at the pin; sync receive reads it directly.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rxd_meta <= 1'b1;
            rxd_s <= 1'b1;
        end else begin
            rxd_meta <= rxd_in;
            rxd_s <= rxd_meta;
        end
    end

    // ****************************************
    // Sync mode control
    // ****************************************

    wire m0_idle = (m0_state == M0_IDLE);
    wire m0_tx_go = is_m0 && m0_idle && wr_buf;
    // A write wins over a pending reception start.
    wire m0_rx_go = is_m0 && m0_idle && !wr_buf && ren && !rx_done_flag;
    wire m0_last = rif.m0_bit_end && (m0_count == sp_pkg::LAST_DATA_BIT);
    wire m0_tx_done = (m0_state == M0_TX) && m0_last;
    wire m0_last_rise = rif.m0_rise && (m0_count == sp_pkg::LAST_DATA_BIT);
    wire m0_rx_done = (m0_state == M0_RX) && m0_last_rise;
    // Incoming bit appended at the top so the first bit ends at bit 0.
    // The partner is clocked by our own shift clock, so the pin is synchronous here;
    // the two-stage lag would miss the two-clock low time of the fast rate.
    wire [7:0] m0_rx_next = {rxd_in, m0_shift[7:1]};

    // Next state of the shift sequencer; leaving sync mode aborts it.
    always_comb begin
        next_m0_state = m0_state;
        case (m0_state)
            M0_IDLE: begin
                if (m0_tx_go) begin
                    next_m0_state = M0_TX;
                end else if (m0_rx_go) begin
                    next_m0_state = M0_RX;
                end
            end
            M0_TX, M0_RX: begin
                if (m0_last) begin
                    next_m0_state = M0_IDLE;
                end
            end
            default: begin
                next_m0_state = M0_IDLE;
            end
        endcase
        if (!is_m0) begin
            next_m0_state = M0_IDLE;
        end
    end

    // State register.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            m0_state <= M0_IDLE;
        end else begin
            m0_state <= next_m0_state;
        end
    end

    // Bit counter for both directions.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            m0_count <= 3'h0;
        end else if (m0_idle) begin
            m0_count <= 3'h0;
        end else if (rif.m0_bit_end) begin
            m0_count <= m0_count + 3'h1;
        end
    end

    // Shift register: out at each bit end, in at each rising clock.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            m0_shift <= 8'h00;
        end else if (m0_tx_go) begin
            m0_shift <= reg_wdata;
        end else if (m0_state == M0_TX && rif.m0_bit_end) begin
            m0_shift <= {1'b0, m0_shift[7:1]};
        end else if (m0_state == M0_RX && rif.m0_rise) begin
            m0_shift <= m0_rx_next;
        end
    end

    // ****************************************
    // Async transmitter
    // ****************************************

    // Bits leave on the counter rollover, never on the write itself.
    wire tx_roll = rif.sample_tick && (tx_div == sp_pkg::DIV_LAST);
    wire tx_start = is_m1 && wr_buf && !tx_busy;
    wire tx_stop_now = tx_busy && tx_roll && (tx_idx == sp_pkg::ASYNC_STOP_IDX);
    wire m1_tx_done = is_m1 && tx_stop_now;

    // Free-running divide-by-16 of the oversampling tick.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tx_div <= 4'h0;
        end else if (rif.sample_tick) begin
            tx_div <= tx_div + 4'h1;
        end
    end

    // Frame shifter; a write during a frame starts nothing and is lost.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tx_busy <= 1'b0;
            tx_shift <= 10'h3ff;
            tx_idx <= 4'h0;
        end else if (!is_m1) begin
            tx_busy <= 1'b0;
            tx_idx <= 4'h0;
        end else if (tx_start) begin
            tx_busy <= 1'b1;
            tx_shift <= {1'b1, reg_wdata, 1'b0};
            tx_idx <= 4'h0;
        end else if (tx_busy && tx_roll) begin
            tx_shift <= {1'b1, tx_shift[9:1]};
            tx_idx <= tx_idx + 4'h1;
            tx_busy <= !tx_stop_now;
        end
    end

    // ****************************************
    // Async receiver
    // ****************************************

    wire rx_hunting = (rx_state == RX_HUNT);
    wire rx_fall = rif.sample_tick && rxd_prev && !rxd_s;
    wire rx_begin = is_m1 && ren && rx_hunting && rx_fall;
    wire rx_sample = rif.sample_tick && (rx_div >= sp_pkg::VOTE_FIRST) && (rx_div <= sp_pkg::VOTE_LAST);
    wire rx_vote_now = !rx_hunting && rif.sample_tick && (rx_div == sp_pkg::VOTE_LAST);
    // Two of three samples decide the bit.
    wire rx_bit = (rx_votes[1] & rx_votes[0]) | (rx_votes[1] & rxd_s) | (rx_votes[0] & rxd_s);
    wire rx_at_start = (rx_idx == 4'h0);
    wire rx_at_stop = (rx_idx == sp_pkg::ASYNC_STOP_IDX);
    wire rx_abort = rx_vote_now && rx_at_start && rx_bit;
    wire rx_frame_end = rx_vote_now && rx_at_stop;
    wire m1_rx_accept = rx_frame_end && !rx_done_flag && (!sm2 || rx_bit);

    // Line history for the edge detector.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rxd_prev <= 1'b1;
        end else if (rif.sample_tick) begin
            rxd_prev <= rxd_s;
        end
    end

    // Hunt and frame states; dropping the enable abandons a frame.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rx_state <= RX_HUNT;
        end else begin
            case (rx_state)
                RX_HUNT: begin
                    if (rx_begin) begin
                        rx_state <= RX_BITS;
                    end
                end
                RX_BITS: begin
                    if (!is_m1 || !ren || rx_abort || rx_frame_end) begin
                        rx_state <= RX_HUNT;
                    end
                end
                default: begin
                    rx_state <= RX_HUNT;
                end
            endcase
        end
    end

    // Counter restarts on the start edge so slices line up with bits.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rx_div <= 4'h0;
        end else if (rx_begin || rx_hunting) begin
            rx_div <= 4'h0;
        end else if (rif.sample_tick) begin
            rx_div <= rx_div + 4'h1;
        end
    end

    // Samples, bit index and data assembly.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rx_votes <= 2'h0;
            rx_idx <= 4'h0;
            rx_data <= 8'h00;
        end else if (rx_hunting) begin
            rx_idx <= 4'h0;
        end else if (rx_vote_now) begin
            rx_idx <= rx_idx + 4'h1;
            if (!rx_at_start && !rx_at_stop) begin
                rx_data <= {rx_bit, rx_data[7:1]};
            end
        end else if (rx_sample) begin
            rx_votes <= {rx_votes[0], rxd_s};
        end
    end

    // ****************************************
    // Registers seen by software
    // ****************************************

    // Control fields and the rate doubling bit; only software writes them.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            {mode, sm2, ren, tb8} <= sp_pkg::CTRL_RESET[7:3];
            rate_double <= sp_pkg::AUX_RESET[sp_pkg::AUX_DOUBLE];
        end else begin
            if (wr_ctrl) begin
                mode <= reg_wdata[sp_pkg::CTRL_MODE_HI:sp_pkg::CTRL_MODE_LO];
                sm2 <= reg_wdata[sp_pkg::CTRL_SM2];
                ren <= reg_wdata[sp_pkg::CTRL_REN];
                tb8 <= reg_wdata[sp_pkg::CTRL_TB8];
            end
            if (wr_aux) begin
                rate_double <= reg_wdata[sp_pkg::AUX_DOUBLE];
            end
        end
    end

    // Completion flags: set by hardware, cleared only by software.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tx_done_flag <= sp_pkg::CTRL_RESET[sp_pkg::CTRL_TI];
            rx_done_flag <= sp_pkg::CTRL_RESET[sp_pkg::CTRL_RI];
        end else begin
            if (m0_tx_done || m1_tx_done) begin
                tx_done_flag <= 1'b1;
            end else if (wr_ctrl) begin
                tx_done_flag <= reg_wdata[sp_pkg::CTRL_TI];
            end
            if (m0_rx_done || m1_rx_accept) begin
                rx_done_flag <= 1'b1;
            end else if (wr_ctrl) begin
                rx_done_flag <= reg_wdata[sp_pkg::CTRL_RI];
            end
        end
    end

    // Receive buffer behind the shared buffer address, and the received ninth bit.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            serial_buffer <= 8'h00;
            received_ninth_bit <= sp_pkg::CTRL_RESET[sp_pkg::CTRL_RB8];
        end else begin
            if (m0_rx_done) begin
                serial_buffer <= m0_rx_next;
            end else if (m1_rx_accept) begin
                serial_buffer <= rx_data;
            end
            if (m1_rx_accept) begin
                received_ninth_bit <= rx_bit;
            end else if (wr_ctrl) begin
                received_ninth_bit <= reg_wdata[sp_pkg::CTRL_RB8];
            end
        end
    end

    // Read data stand for exactly one cycle after the strobe.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= reg_rd ? read_mux : 8'h00;
        end
    end

    // ****************************************
    // Pins
    // ****************************************

    // Data pin is driven only while shifting out; the partner drives it on receive.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rxd_oe <= 1'b0;
            rxd_out <= 1'b1;
        end else begin
            rxd_oe <= (next_m0_state == M0_TX);
            if (m0_state == M0_TX && rif.m0_bit_start) begin
                rxd_out <= m0_shift[0];
            end
        end
    end

    // Transmit pin: shift clock in sync mode, frame line in async mode.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            txd_out <= 1'b1;
        end else if (is_m0) begin
            if (rif.m0_fall) begin
                txd_out <= 1'b0;
            end else if (rif.m0_rise || m0_idle) begin
                txd_out <= 1'b1;
            end
        end else if (is_m1 && tx_busy && tx_roll) begin
            txd_out <= tx_shift[0];
        end else if (!is_m1 || !tx_busy) begin
            txd_out <= 1'b1;
        end
    end

endmodule

`default_nettype wire

// ===== sp_pkg.sv
// Shared constants of the serial port: register map, field layout and timing.
// Assumes a single system clock that is also the oscillator clock.
`default_nettype none

package sp_pkg;

    // ****************************************
    // Register map
    // ****************************************

    // Word offsets on the register port.
    localparam logic [1:0] ADDR_CTRL = 2'h0;
    localparam logic [1:0] ADDR_BUF = 2'h1;
    localparam logic [1:0] ADDR_AUX = 2'h2;

    // Field positions in serial_control_reg.
    localparam int CTRL_MODE_HI = 7;
    localparam int CTRL_MODE_LO = 6;
    localparam int CTRL_SM2 = 5;
    localparam int CTRL_REN = 4;
    localparam int CTRL_TB8 = 3;
    localparam int CTRL_RB8 = 2;
    localparam int CTRL_TI = 1;
    localparam int CTRL_RI = 0;
    // Field position of the rate doubling bit in the auxiliary register.
    localparam int AUX_DOUBLE = 0;

    // Reset values.
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] AUX_RESET = 8'h00;

    // Mode field codes.
    localparam logic [1:0] MODE_SYNC = 2'h0;
    localparam logic [1:0] MODE_ASYNC = 2'h1;

    // ****************************************
    // Timing
    // ****************************************

    // Shift clock phases in oscillator clocks: data lead, then low time.
    localparam logic [3:0] M0_FAST_LEAD = 4'h1;
    localparam logic [3:0] M0_FAST_LOW = 4'h2;
    localparam logic [3:0] M0_FAST_LAST = 4'h3;
    localparam logic [3:0] M0_SLOW_LEAD = 4'h3;
    localparam logic [3:0] M0_SLOW_LOW = 4'h6;
    localparam logic [3:0] M0_SLOW_LAST = 4'hb;

    // Index of the last data bit of a byte.
    localparam logic [2:0] LAST_DATA_BIT = 3'h7;
    // Index of the stop bit among the ten bit times of an async frame.
    localparam logic [3:0] ASYNC_STOP_IDX = 4'h9;
    // Last state of the divide-by-16 counter.
    localparam logic [3:0] DIV_LAST = 4'hf;
    // Counter states of the three votes (8th, 9th and 10th states).
    localparam logic [3:0] VOTE_FIRST = 4'h7;
    localparam logic [3:0] VOTE_LAST = 4'h9;

endpackage

`default_nettype wire

// ===== sp_rate_if.sv
// Rate signals between the serial port core and its rate generator.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
`default_nettype none

interface sp_rate_if;
    logic m0_run; // Shift clock sequence is running.
    logic m0_fast; // Quarter rate selected.
    logic m0_bit_start; // Pulse: first clock of a bit time.
    logic m0_fall; // Pulse: shift clock is to go low.
    logic m0_rise; // Pulse: shift clock is to go high.
    logic m0_bit_end; // Pulse: last clock of a bit time.
    logic ovf; // Timer overflow pulse.
    logic rate_double; // Sixteenth divisor selected.
    logic sample_tick; // Pulse at sixteen times the bit rate.

    modport gen(
        input m0_run, m0_fast, ovf, rate_double,
        output m0_bit_start, m0_fall, m0_rise, m0_bit_end, sample_tick
    );
    modport core(
        output m0_run, m0_fast, ovf, rate_double,
        input m0_bit_start, m0_fall, m0_rise, m0_bit_end, sample_tick
    );
endinterface

`default_nettype wire

// ===== sp_rate_gen.sv
// Rate generator: shift clock phases and async oversampling tick.
// Assumes the timer overflow is a one-cycle pulse on the same clock.
`timescale 1ns/10ps
`default_nettype none

module sp_rate_gen (
    input wire logic clock,
    input wire logic rst_n,
    sp_rate_if.gen rif
);

    // ****************************************
    // Shift clock phase counter
    // ****************************************

    logic [3:0] phase; // Clock within the current bit time.
    logic ovf_half; // Toggles on each overflow for the halved rate.

    // Phase points of the selected rate.
    wire [3:0] lead = rif.m0_fast ? sp_pkg::M0_FAST_LEAD : sp_pkg::M0_SLOW_LEAD;
    wire [3:0] low = rif.m0_fast ? sp_pkg::M0_FAST_LOW : sp_pkg::M0_SLOW_LOW;
    wire [3:0] last = rif.m0_fast ? sp_pkg::M0_FAST_LAST : sp_pkg::M0_SLOW_LAST;
    wire [3:0] rise_at = 4'(lead + low);

    assign rif.m0_bit_start = rif.m0_run && (phase == 4'h0);
    assign rif.m0_fall = rif.m0_run && (phase == lead);
    assign rif.m0_rise = rif.m0_run && (phase == rise_at);
    assign rif.m0_bit_end = rif.m0_run && (phase == last);

    // The counter sits at zero while idle so every byte starts aligned.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            phase <= 4'h0;
        end else if (!rif.m0_run || rif.m0_bit_end) begin
            phase <= 4'h0;
        end else begin
            phase <= phase + 4'h1;
        end
    end

    // ****************************************
    // Oversampling tick
    // ****************************************

    // Every overflow when doubled, every second overflow otherwise.
    assign rif.sample_tick = rif.ovf && (rif.rate_double || ovf_half);

    // Prescaler for the thirty-second divisor.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ovf_half <= 1'b0;
        end else if (rif.ovf) begin
            ovf_half <= !ovf_half;
        end
    end

endmodule

`default_nettype wire

// ===== sp_serial_port_chk.sv
// Checker for the serial port pins and register port.
// Assumes it is bound onto every sp_serial_port instance.
`timescale 1ns/10ps
`default_nettype none
module sp_serial_port_chk (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic timer_ovf,
    input wire logic rxd_out,
    input wire logic rxd_oe,
    input wire logic txd_out
);
    // ****
    // Control mirror and properties
    // ****
    logic [7:0] cr; // Last control byte written; only software owns its upper bits.
    // The mirror lets timing checks know the mode and rate without looking inside.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) cr <= 8'h00;
        else if (reg_wr && reg_addr == 2'h0) cr <= reg_wdata;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data out of slot");
    property p_unmap; reg_rd && reg_addr == 2'h3 |=> reg_rdata == 8'h00; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_ctrl; reg_rd && reg_addr == 2'h0 |=> reg_rdata[7:3] == cr[7:3]; endproperty
    a_ctrl: assert property (p_ctrl) else $error("control readback wrong");
    property p_oe_mode; rxd_oe |-> cr[7:6] == 2'h0; endproperty
    a_oe_mode: assert property (p_oe_mode) else $error("data pin driven outside sync mode");
    property p_fast; $rose(rxd_oe) && cr[5] |-> txd_out[*2] ##1 !txd_out[*2] ##1 txd_out; endproperty
    a_fast: assert property (p_fast) else $error("fast shift clock shape wrong");
    property p_slow; $rose(rxd_oe) && !cr[5] |-> txd_out[*4] ##1 !txd_out[*6] ##1 txd_out; endproperty
    a_slow: assert property (p_slow) else $error("slow shift clock shape wrong");
    property p_dur; $rose(rxd_oe) && cr[5] |-> (rxd_oe throughout ##31 1'b1) ##1 !rxd_oe; endproperty
    a_dur: assert property (p_dur) else $error("fast byte length wrong");
    property p_ovf; cr[7:6] == 2'h1 && $changed(txd_out) |-> $past(timer_ovf); endproperty
    a_ovf: assert property (p_ovf) else $error("async bit edge off tick");
    c_fast: cover property ($rose(rxd_oe) && cr[5]);
    c_slow: cover property ($rose(rxd_oe) && !cr[5]);
    c_async: cover property (cr[7:6] == 2'h1 && $fell(txd_out));
endmodule
bind sp_serial_port sp_serial_port_chk sp_serial_port_chk_i (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer_ovf(timer_ovf),
    .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd_out(txd_out));
`default_nettype wire

// ===== sp_far_model.sv
// Far end: shift register in sync mode, serial station in async mode.
// Assumes the bench resolves the data pin from both drivers.
`timescale 1ns/10ps
`default_nettype none
module sp_far_model (
    input wire logic clock,
    input wire logic sync,
    input wire logic shift_clk,
    input wire logic pin,
    output logic line
);
    logic [7:0] shreg = 8'h00; // Byte offered; refills with inverse bits so no value lingers.
    logic [7:0] got = 8'h00; // Bits captured from the device.
    initial line = 1'b1;
    // New data only on the falling shift clock, so it is settled at the rise.
    always @(negedge shift_clk) begin
        if (sync) begin
            line <= shreg[0];
            shreg <= {~shreg[0], shreg[7:1]};
        end
    end
    // Capture on the rising shift clock from the level held half a clock earlier:
    // the device may release the pin on that very edge.
    logic mid = 1'b1;
    always @(negedge clock) mid <= pin;
    always @(posedge shift_clk) got <= {mid, got[7:1]};
    // Send ten bits, lowest first, each n clocks long.
    task send(input logic [9:0] f, input int n);
        for (int i = 0; i < 10; i++) begin
            line <= f[i];
            repeat (n) @(posedge clock);
        end
    endtask
endmodule
`default_nettype wire

// ===== sp_serial_port_bench.sv
// Bench: register tasks and directed scenarios for the serial port.
// Assumes sp_far_model stands on the pins.
`timescale 1ns/10ps
`default_nettype none
module sp_serial_port_bench;
    logic clock = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, timer_ovf = 1'b0, sync = 1'b1;
    logic line, rxd_out, rxd_oe, txd_out;
    logic [1:0] reg_addr = 2'h0, oc = 2'h0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata;
    logic [9:0] v;
    int fail_count = 0, tests_run = 0, cyc = 0;
    wire logic pin = rxd_oe ? rxd_out : line; // Resolved data pin.
    sp_serial_port sp_serial_port_i (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer_ovf(timer_ovf), .rxd_in(pin),
        .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd_out(txd_out));
    sp_far_model sp_far_model_i (.clock(clock), .sync(sync), .shift_clk(txd_out), .pin(pin), .line(line));
    initial forever #50 clock = ~clock;
    // Overflow every fourth clock: a doubled-rate bit lasts 64 clocks. Also the hang limit.
    always @(posedge clock) begin
        oc <= oc + 2'h1;
        timer_ovf <= (oc == 2'h3);
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            conclude();
        end
    end
    task chk(input logic [9:0] s, input logic [9:0] e);
        tests_run++;
        if (s !== e) begin
            fail_count++;
            $display("BAD %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task conclude();
        if (fail_count == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task wr(input logic [1:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
        @(posedge clock);
    endtask
    task w(input int n);
        repeat (n) @(posedge clock);
    endtask
    task rd(input logic [1:0] a, input logic [7:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(negedge clock);
        chk({2'h0, reg_rdata}, {2'h0, e});
        @(posedge clock);
    endtask
    // Wait for the start edge, then sample each bit at its middle.
    task frame(input logic [7:0] d);
        for (int i = 0; i < 2000 && txd_out; i++) @(posedge clock);
        w(32);
        for (int i = 0; i < 10; i++) begin
            v[i] = txd_out;
            w(64);
        end
        chk(v, {1'b1, d, 1'b0});
    endtask
    initial begin
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        rd(2'h0, 8'h00);
        rd(2'h2, 8'h00);
        rd(2'h3, 8'h00);
        wr(2'h0, 8'h20);
        wr(2'h1, 8'ha5);
        w(50);
        chk({2'h0, sp_far_model_i.got}, 10'h0a5);
        rd(2'h0, 8'h22);
        wr(2'h0, 8'h00);
        wr(2'h1, 8'h3c);
        w(110);
        chk({2'h0, sp_far_model_i.got}, 10'h03c);
        sp_far_model_i.shreg = 8'h96;
        wr(2'h0, 8'h10);
        w(110);
        rd(2'h0, 8'h11);
        w(30);
        chk({9'h000, txd_out}, 10'h001);
        rd(2'h1, 8'h96);
        sync = 1'b0;
        sp_far_model_i.send(10'h3ff, 1);
        wr(2'h2, 8'h01);
        wr(2'h0, 8'h50);
        wr(2'h1, 8'h5a);
        frame(8'h5a);
        rd(2'h0, 8'h52);
        sp_far_model_i.send(10'h278, 64);
        rd(2'h1, 8'h3c);
        rd(2'h0, 8'h57);
        sp_far_model_i.send(10'h3fe, 64);
        rd(2'h1, 8'h3c);
        wr(2'h0, 8'h70);
        sp_far_model_i.send(10'h022, 64);
        rd(2'h0, 8'h70);
        sp_far_model_i.send(10'h3fd, 16);
        sp_far_model_i.send(10'h386, 64);
        rd(2'h1, 8'hc3);
        rd(2'h0, 8'h75);
        conclude();
    end
endmodule
`default_nettype wire
